// ### logic/supply_monitor_defs.svh
// Register map, field positions, reset values and timing of the monitor
`ifndef SUPPLY_MONITOR_DEFS_SVH
`define SUPPLY_MONITOR_DEFS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define SVM_ADDR_STATUS 4'h0
`define SVM_ADDR_ENABLE 4'h1
`define SVM_ADDR_CTRL0 4'h2
`define SVM_ADDR_CTRL1 4'h3
`define SVM_ADDR_CTRL2 4'h4
`define SVM_ADDR_IRQ_STAT 4'h5
`define SVM_ADDR_IRQ_MASK 4'h6

// ****************************************************************
// Field positions
// ****************************************************************
`define SVM_STAT_LVL1 0
`define SVM_STAT_LVL2 1
`define SVM_EN_SETTLED_LO 4
`define SVM_IRQ_DET1 0
`define SVM_IRQ_DET2 1

// ****************************************************************
// Reset values
// ****************************************************************
`define SVM_ENABLE_RST 3'h1
`define SVM_CTRL0_RST 8'h01
`define SVM_CTRLX_RST 8'h00
`define SVM_IRQ_RST 2'h0

// ****************************************************************
// Timing
// ****************************************************************
`define SVM_CLK_PERIOD_NS 5
`define SVM_RESTART_SLOW 6'h20
`define SVM_SAMPLE_PERIODS 6'h04
`define SVM_FILT_TAPS 4

`endif

// ### logic/supply_monitor_pkg.sv
// Types shared by the supply monitor modules
package supply_monitor_pkg;

    // Per-detector control byte
    typedef struct packed {
        logic [1:0] spare;
        logic fall_sel;
        logic rst_mode;
        logic [1:0] div_sel;
        logic filt_en;
        logic act_en;
    } det_ctrl_s;

    // Level and crossing pulses of one detector
    typedef struct packed {
        logic level;
        logic rise;
        logic fall;
    } det_evt_s;

    // Restart sequencer, Gray along idle, hold, count
    typedef enum logic [1:0] {
        RST_IDLE = 2'h0,
        RST_HOLD = 2'h1,
        RST_COUNT = 2'h3
    } rst_state_e;

endpackage : supply_monitor_pkg

// ### logic/level_filter.sv
// Synchroniser, sampling filter and crossing detector for one comparator
`timescale 1ns/10ps
`default_nettype none
`include "supply_monitor_defs.svh"

module level_filter (
    input wire logic clk,
    input wire logic resetn,
    input wire logic slow_edge,
    input wire logic [1:0] div_sel,
    input wire logic filt_en,
    input wire logic raw,
    output var supply_monitor_pkg::det_evt_s evt
);

    logic sync1;
    logic sync2;
    logic [5:0] pre;
    logic tick;
    logic [`SVM_FILT_TAPS-1:0] samples;
    logic filt_level;
    logic level;
    logic prev;

    // **********
    // Synchroniser, reset high so power-up gives no false fall
    // **********
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sync1 <= 1'b1;
            sync2 <= 1'b1;
        end else begin
            sync1 <= raw; // see [RQ14]
            sync2 <= sync1;
        end
    end

    // **********
    // Sample tick every four divided slow periods
    // **********
    assign tick = slow_edge &&
        (pre == (`SVM_SAMPLE_PERIODS << div_sel) - 6'h01); // see [RQ7]

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pre <= 6'h00;
        end else if (tick) begin
            pre <= 6'h00;
        end else if (slow_edge) begin
            pre <= pre + 6'h01;
        end
    end

    // **********
    // Filter: level moves only on a full run of equal samples
    // **********
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            samples <= '1;
        end else if (tick) begin
            samples <= {samples[`SVM_FILT_TAPS-2:0], sync2}; // see [RQ14]
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            filt_level <= 1'b1;
        end else if (samples == '1) begin
            filt_level <= 1'b1; // see [RQ14]
        end else if (samples == '0) begin
            filt_level <= 1'b0;
        end
    end

    // Bypass trades noise immunity for a response in two clocks
    assign level = filt_en ? filt_level : sync2; // see [RQ7]

    // **********
    // Crossing detection in both directions
    // **********
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prev <= 1'b1;
            evt <= '{level: 1'b1, rise: 1'b0, fall: 1'b0};
        end else begin
            prev <= level;
            evt.level <= level;
            evt.rise <= level && !prev; // see [RQ4]
            evt.fall <= !level && prev; // see [RQ4]
        end
    end

endmodule : level_filter
`default_nettype wire

// ### logic/supply_voltage_monitor_logic.sv
// Digital part of a three-level supply supervisor: resets, interrupts, status
//
// Contract
// [RQ1] Detector zero holds reset while supply is low, releases after it rises.
// [RQ2] Detectors one/two in reset mode reset on fall, restart after fixed delay.
// [RQ3] Without detector zero, detector one reset follows supply like zero does.
// [RQ4] Every threshold detects both falling and rising crossings as events.
// [RQ5] Filter on: interrupt detector requests on both crossing directions.
// [RQ6] Filter off: interrupt detector requests on one selected direction only.
// [RQ7] Filter switchable; sampling period is four slow periods divided by 1-8.
// [RQ8] Three-detector variant: readable level-one flag; none for detector zero.
// [RQ9] A readable level-two flag exists in every variant.
// [RQ10] Level-two flag tracks comparator when enabled, reads 1 when disabled.
// [RQ11] Level-two status survives software, watchdog and detector resets.
// [RQ12] After supply rises, count 32 slow clocks before releasing reset.
// [RQ13] Detector two waits a settling delay after enable goes from 0 to 1.
// [RQ14] Comparators synchronised; filtered level needs four equal samples.
//
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "supply_monitor_defs.svh"

module supply_voltage_monitor_logic #(
    parameter bit HAS_DET0 = 1'b1,
    parameter int SETTLE_NS = 100000,
    parameter int ADDR_W = 4,
    parameter int DATA_W = 8
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic slow_osc_clock,
    input wire logic [2:0] cmp_above,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [DATA_W-1:0] rd_data,
    output logic sys_reset_req,
    output logic irq
);

    localparam int SETTLE_CYCLES =
        (SETTLE_NS + `SVM_CLK_PERIOD_NS - 1) / `SVM_CLK_PERIOD_NS;
    localparam int SETTLE_W = $clog2(SETTLE_CYCLES + 1);

    // **********
    // Declarations
    // **********
    logic slow_q;
    logic slow_edge;
    logic [2:0] detect_enable_reg;
    logic [2:0] en_q;
    logic [2:0] settled;
    logic [2:0] active;
    supply_monitor_pkg::det_ctrl_s ctrl [3];
    supply_monitor_pkg::det_evt_s evt [3];
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [1:0] irq_set;
    logic level1_compare_flag;
    logic level2_compare_flag;
    logic below_hold;
    logic timed_trig;
    supply_monitor_pkg::rst_state_e state;
    supply_monitor_pkg::rst_state_e next_state;
    logic [5:0] restart_cnt;
    logic stat_rd;

    // **********
    // Helpers
    // **********
    // Interrupt hit of one detector from its control byte and crossings
    function automatic logic irq_hit(
        input supply_monitor_pkg::det_ctrl_s c,
        input supply_monitor_pkg::det_evt_s e
    );
        logic hit;
        hit = 1'b0;
        if (c.act_en && !c.rst_mode) begin
            if (c.filt_en) begin
                hit = e.rise || e.fall; // see [RQ5]
            end else if (c.fall_sel) begin
                hit = e.fall; // see [RQ6]
            end else begin
                hit = e.rise; // see [RQ6]
            end
        end
        return hit;
    endfunction : irq_hit

    // Reset-mode fall of one detector
    function automatic logic rst_fall(
        input supply_monitor_pkg::det_ctrl_s c,
        input supply_monitor_pkg::det_evt_s e
    );
        return c.act_en && c.rst_mode && e.fall;
    endfunction : rst_fall

    // **********
    // Slow oscillator edge, sampled as an ordinary input
    // **********
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            slow_q <= 1'b0;
        end else begin
            slow_q <= slow_osc_clock;
        end
    end

    assign slow_edge = slow_osc_clock && !slow_q;

    // **********
    // Detector channels and settling after enable
    // **********
    generate
        for (genvar i = 0; i < 3; i++) begin : g_det
            logic [SETTLE_W-1:0] settle_cnt;

            level_filter u_filter (
                .clk(clk),
                .resetn(resetn),
                .slow_edge(slow_edge),
                .div_sel(ctrl[i].div_sel),
                .filt_en(ctrl[i].filt_en),
                .raw(cmp_above[i]),
                .evt(evt[i])
            );

            // A fresh enable restarts the wait; settled drops one clock after enable clears
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    settle_cnt <= '0;
                end else if (!detect_enable_reg[i]) begin
                    settle_cnt <= '0;
                end else if (!en_q[i]) begin
                    settle_cnt <= SETTLE_W'(SETTLE_CYCLES); // see [RQ13]
                end else if (settle_cnt != '0) begin
                    settle_cnt <= settle_cnt - 1'b1;
                end
            end

            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    settled[i] <= 1'b0;
                end else begin
                    settled[i] <= detect_enable_reg[i] && en_q[i] &&
                        settle_cnt == '0; // see [RQ13]
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            en_q <= 3'h0;
        end else begin
            en_q <= detect_enable_reg;
        end
    end

    // Events are ignored until a detector has settled
    assign active = detect_enable_reg & settled; // see [RQ13]

    // **********
    // Reset request conditions
    // **********
    always_comb begin
        below_hold = 1'b0;
        timed_trig = 1'b0;
        if (HAS_DET0) begin
            below_hold = active[0] && ctrl[0].act_en &&
                !evt[0].level; // see [RQ1]
            timed_trig = active[1] && rst_fall(ctrl[1], evt[1]); // see [RQ2]
        end else begin
            below_hold = active[1] && ctrl[1].act_en && ctrl[1].rst_mode &&
                !evt[1].level; // see [RQ3]
        end
        if (active[2] && rst_fall(ctrl[2], evt[2])) begin
            timed_trig = 1'b1; // see [RQ2]
        end
    end

    // **********
    // Restart sequencer
    // **********
    // The level hold always wins over a pending timed restart
    always_comb begin
        next_state = state;
        case (state)
            supply_monitor_pkg::RST_IDLE: begin
                if (below_hold) begin
                    next_state = supply_monitor_pkg::RST_HOLD; // see [RQ1]
                end else if (timed_trig) begin
                    next_state = supply_monitor_pkg::RST_COUNT; // see [RQ2]
                end
            end
            supply_monitor_pkg::RST_HOLD: begin
                if (!below_hold) begin
                    next_state = supply_monitor_pkg::RST_COUNT; // see [RQ12]
                end
            end
            supply_monitor_pkg::RST_COUNT: begin
                if (below_hold) begin
                    next_state = supply_monitor_pkg::RST_HOLD;
                end else if (!timed_trig && slow_edge &&
                    restart_cnt == 6'h01) begin
                    next_state = supply_monitor_pkg::RST_IDLE; // see [RQ12]
                end
            end
            default: begin
                next_state = supply_monitor_pkg::RST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= supply_monitor_pkg::RST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            restart_cnt <= 6'h00;
        end else if (next_state == supply_monitor_pkg::RST_COUNT &&
            (state != supply_monitor_pkg::RST_COUNT || timed_trig)) begin
            restart_cnt <= `SVM_RESTART_SLOW; // see [RQ12]
        end else if (state == supply_monitor_pkg::RST_COUNT && slow_edge) begin
            restart_cnt <= restart_cnt - 6'h01; // see [RQ2]
        end
    end

    // Request stands for the whole hold and count
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sys_reset_req <= 1'b0;
        end else begin
            sys_reset_req <= next_state != supply_monitor_pkg::RST_IDLE;
        end
    end

    // **********
    // Status flags
    // **********
    // Built from live levels only; the system reset this block raises
    // never feeds back, so the flags outlive every reset but resetn
    assign level1_compare_flag = HAS_DET0 &&
        (!detect_enable_reg[1] || evt[1].level); // see [RQ8]
    assign level2_compare_flag = !detect_enable_reg[2] ||
        evt[2].level; // see [RQ9] see [RQ10] see [RQ11]

    // **********
    // Interrupt status, read clears, a new set wins
    // **********
    assign irq_set[`SVM_IRQ_DET1] = HAS_DET0 && active[1] &&
        irq_hit(ctrl[1], evt[1]);
    assign irq_set[`SVM_IRQ_DET2] = active[2] && irq_hit(ctrl[2], evt[2]);
    assign stat_rd = rd_stb && addr == `SVM_ADDR_IRQ_STAT;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq_stat <= `SVM_IRQ_RST;
        end else if (stat_rd) begin
            irq_stat <= irq_set;
        end else begin
            irq_stat <= irq_stat | irq_set;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq <= 1'b0;
        end else if (stat_rd) begin
            irq <= |(irq_set & irq_mask);
        end else begin
            irq <= |((irq_stat | irq_set) & irq_mask);
        end
    end

    // **********
    // Register writes
    // **********
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            detect_enable_reg <= `SVM_ENABLE_RST;
        end else if (wr_stb && addr == `SVM_ADDR_ENABLE) begin
            detect_enable_reg <= wr_data[2:0];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl[0] <= `SVM_CTRL0_RST;
            ctrl[1] <= `SVM_CTRLX_RST;
            ctrl[2] <= `SVM_CTRLX_RST;
        end else if (wr_stb) begin
            if (addr == `SVM_ADDR_CTRL0) begin
                ctrl[0] <= wr_data;
            end else if (addr == `SVM_ADDR_CTRL1) begin
                ctrl[1] <= wr_data;
            end else if (addr == `SVM_ADDR_CTRL2) begin
                ctrl[2] <= wr_data;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq_mask <= `SVM_IRQ_RST;
        end else if (wr_stb && addr == `SVM_ADDR_IRQ_MASK) begin
            irq_mask <= wr_data[1:0];
        end
    end

    // **********
    // Register reads, data in the next cycle only
    // **********
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rd_data <= '0;
        end else if (!rd_stb) begin
            rd_data <= '0;
        end else if (addr == `SVM_ADDR_STATUS) begin
            rd_data <= '0;
            rd_data[`SVM_STAT_LVL1] <= level1_compare_flag;
            rd_data[`SVM_STAT_LVL2] <= level2_compare_flag;
        end else if (addr == `SVM_ADDR_ENABLE) begin
            rd_data <= '0;
            rd_data[2:0] <= detect_enable_reg;
            rd_data[`SVM_EN_SETTLED_LO +: 3] <= settled;
        end else if (addr == `SVM_ADDR_CTRL0) begin
            rd_data <= ctrl[0];
        end else if (addr == `SVM_ADDR_CTRL1) begin
            rd_data <= ctrl[1];
        end else if (addr == `SVM_ADDR_CTRL2) begin
            rd_data <= ctrl[2];
        end else if (addr == `SVM_ADDR_IRQ_STAT) begin
            rd_data <= '0;
            rd_data[1:0] <= irq_stat;
        end else if (addr == `SVM_ADDR_IRQ_MASK) begin
            rd_data <= '0;
            rd_data[1:0] <= irq_mask;
        end else begin
            rd_data <= '0;
        end
    end

endmodule : supply_voltage_monitor_logic
`default_nettype wire

// ### bench/supply_rail_model.sv
// Model of the comparators and the slow on-chip oscillator
`timescale 1ns/10ps
`default_nettype none

module supply_rail_model #(
    parameter real SLOW_HALF_NS = 21.3
) (
    input wire logic [2:0] rail,
    output logic slow_osc_clock,
    output wire logic [2:0] cmp_above
);
    // **********
    // Oscillator and comparators
    // **********
    // Phase unrelated to clk
    initial begin
        slow_osc_clock = 1'b0;
        forever #(SLOW_HALF_NS) slow_osc_clock = ~slow_osc_clock;
    end
    // Lag keeps crossings off the clk grid
    assign #3 cmp_above = rail;
endmodule : supply_rail_model
`default_nettype wire

// ### bench/supply_monitor_props.sv
// Checker of the supply monitor port behaviour
`timescale 1ns/10ps
`default_nettype none
`include "supply_monitor_defs.svh"

module supply_monitor_props #(
    parameter bit HAS_DET0 = 1'b1,
    parameter int SETTLE_NS = 100000,
    parameter int ADDR_W = 4,
    parameter int DATA_W = 8
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic slow_osc_clock,
    input wire logic [2:0] cmp_above,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [DATA_W-1:0] rd_data,
    input wire logic sys_reset_req,
    input wire logic irq
);
    localparam int SC = SETTLE_NS / `SVM_CLK_PERIOD_NS;
    logic [2:0] en_sh;
    logic [7:0] ctrl0_sh;
    logic [1:0] mask_sh;
    logic slow_q;
    logic [5:0] hold_ticks;
    logic [7:0] hi_ticks;
    int cnt0, cnt2;
    wire logic tick = slow_osc_clock && !slow_q;

    // **********
    // Shadow state
    // **********
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            en_sh <= `SVM_ENABLE_RST;
            ctrl0_sh <= `SVM_CTRL0_RST;
            mask_sh <= `SVM_IRQ_RST;
        end else if (wr_stb) begin
            if (addr == `SVM_ADDR_ENABLE) begin
                en_sh <= wr_data[2:0];
            end
            if (addr == `SVM_ADDR_CTRL0) begin
                ctrl0_sh <= wr_data[7:0];
            end
            if (addr == `SVM_ADDR_IRQ_MASK) begin
                mask_sh <= wr_data[1:0];
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt0 <= 0;
            cnt2 <= 0;
        end else begin
            cnt0 <= !en_sh[0] ? 0 : (cnt0 < SC ? cnt0 + 1 : cnt0);
            cnt2 <= !en_sh[2] ? 0 : (cnt2 < SC ? cnt2 + 1 : cnt2);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            slow_q <= 1'b0;
            hold_ticks <= 6'h00;
            hi_ticks <= 8'h00;
        end else begin
            slow_q <= slow_osc_clock;
            hold_ticks <= !sys_reset_req ? 6'h00 :
                hold_ticks + 6'(tick && hold_ticks != 6'h3F);
            hi_ticks <= !(&cmp_above) ? 8'h00 :
                hi_ticks + 8'(tick && hi_ticks != 8'hFF);
        end
    end

    // **********
    // Assertions
    // **********
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    property p_rd_idle;
        !$past(rd_stb) |-> rd_data == '0;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("stray read data");
    property p_level_hold;
        (!cmp_above[0] && en_sh[0] && ctrl0_sh[0] && !ctrl0_sh[1]
            && cnt0 >= SC)[*6] |-> sys_reset_req;
    endproperty
    a_level_hold: assert property (p_level_hold)
        else $error("no reset while low");
    property p_restart_min;
        $fell(sys_reset_req) |-> hold_ticks >= 6'd31;
    endproperty
    a_restart_min: assert property (p_restart_min)
        else $error("early release");
    property p_release_bound;
        hi_ticks >= 8'd200 |-> !sys_reset_req;
    endproperty
    a_release_bound: assert property (p_release_bound)
        else $error("reset held high");
    property p_st2_off;
        rd_stb && addr == `SVM_ADDR_STATUS && !en_sh[2] |=> rd_data[1];
    endproperty
    a_st2_off: assert property (p_st2_off)
        else $error("level two flag off");
    property p_st1_off;
        rd_stb && addr == `SVM_ADDR_STATUS && !en_sh[1]
            |=> rd_data[0] == HAS_DET0;
    endproperty
    a_st1_off: assert property (p_st1_off)
        else $error("level one flag off");
    property p_mask_quiet;
        $past(mask_sh) == 2'h0 && mask_sh == 2'h0 |-> !irq;
    endproperty
    a_mask_quiet: assert property (p_mask_quiet)
        else $error("masked irq");
    property p_settle_quiet;
        $rose(irq) |-> en_sh[1] || cnt2 >= SC;
    endproperty
    a_settle_quiet: assert property (p_settle_quiet)
        else $error("irq unsettled");

    c_restart: cover property ($fell(sys_reset_req));
    c_irq: cover property ($rose(irq));
    c_status: cover property (rd_stb && addr == `SVM_ADDR_STATUS);
endmodule : supply_monitor_props

bind supply_voltage_monitor_logic supply_monitor_props #(
    .HAS_DET0(HAS_DET0), .SETTLE_NS(SETTLE_NS), .ADDR_W(ADDR_W),
    .DATA_W(DATA_W)
) u_props (
    .clk(clk), .resetn(resetn), .slow_osc_clock(slow_osc_clock),
    .cmp_above(cmp_above), .addr(addr), .wr_data(wr_data),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
    .sys_reset_req(sys_reset_req), .irq(irq)
);
`default_nettype wire

// ### bench/tb_supply_voltage_monitor_logic.sv
// Self-checking bench of the supply monitor
`timescale 1ns/10ps
`default_nettype none
`include "supply_monitor_defs.svh"

module tb_supply_voltage_monitor_logic;
    logic clk, resetn, wr_stb, rd_stb, pend;
    logic [3:0] addr;
    logic [7:0] wr_data, rv;
    logic [2:0] rail;
    wire logic slow_osc_clock, sys_reset_req, irq;
    wire logic [2:0] cmp_above;
    wire logic [7:0] rd_data;
    logic [7:0] expq[$];
    int errors, cmp_count, n, d;

    supply_voltage_monitor_logic #(.SETTLE_NS(50)) dut (
        .clk(clk), .resetn(resetn), .slow_osc_clock(slow_osc_clock),
        .cmp_above(cmp_above), .addr(addr), .wr_data(wr_data),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
        .sys_reset_req(sys_reset_req), .irq(irq)
    );
    supply_rail_model rail_m (
        .rail(rail), .slow_osc_clock(slow_osc_clock),
        .cmp_above(cmp_above)
    );

    // **********
    // Bus tasks
    // **********
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t ns: seen %2h expected %2h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("Compares %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wr_data <= v;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask : wr

    // Expected answer is queued for the monitor
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        expq.push_back(e);
        @(posedge clk);
        rd_stb <= 1'b0;
    endtask : rd

    // Sampled mid-cycle so the launching edge has settled
    task automatic wait_out(input bit rst, input logic v, input int max);
        n = 0;
        @(negedge clk);
        while ((rst ? sys_reset_req : irq) !== v && n < max) begin
            @(negedge clk);
            n++;
        end
        check({7'h00, rst ? sys_reset_req : irq}, {7'h00, v});
    endtask : wait_out

    task automatic idle(input int c);
        repeat (c) @(posedge clk);
    endtask : idle

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (pend) begin
            check(rd_data, expq.pop_front());
        end
        pend <= rd_stb;
    end

    initial begin
        idle(60000);
        errors++;
        tally_and_finish();
    end

    // **********
    // Scenarios
    // **********
    initial begin
        resetn = 1'b0;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        addr = 4'h0;
        wr_data = 8'h00;
        rail = 3'h7;
        void'($urandom(32'hBEB2));
        idle(20);
        resetn <= 1'b1;
        wait_out(1'b1, 1'b0, 0);
        idle(20);
        rd(`SVM_ADDR_ENABLE, 8'h11);
        rd(`SVM_ADDR_CTRL0, 8'h01);
        rd(`SVM_ADDR_IRQ_MASK, 8'h00);
        rd(4'h7, 8'h00);
        // Detector one stays inert: no action, no filter
        rv = 8'($urandom) & 8'hFC;
        wr(`SVM_ADDR_CTRL1, rv);
        rd(`SVM_ADDR_CTRL1, rv);
        rail[2] <= 1'b0;
        idle(10);
        rd(`SVM_ADDR_STATUS, 8'h03);
        wr(`SVM_ADDR_CTRL2, 8'h21);
        wr(`SVM_ADDR_IRQ_MASK, 8'h02);
        rail[2] <= 1'b1;
        wr(`SVM_ADDR_ENABLE, 8'h05);
        rail[2] <= 1'b0;
        rd(`SVM_ADDR_ENABLE, 8'h15);
        idle(20);
        rd(`SVM_ADDR_ENABLE, 8'h55);
        rd(`SVM_ADDR_IRQ_STAT, 8'h00);
        rd(`SVM_ADDR_STATUS, 8'h01);
        for (d = 1; d >= 0; d--) begin
            wr(`SVM_ADDR_CTRL2, 8'h00);
            rail[2] <= !d[0];
            idle(10);
            rd(`SVM_ADDR_IRQ_STAT, 8'h00);
            wr(`SVM_ADDR_CTRL2, {2'h0, d[0], 5'h01});
            rail[2] <= d[0];
            idle(20);
            wait_out(1'b0, 1'b0, 0);
            rail[2] <= !d[0];
            wait_out(1'b0, 1'b1, 20);
            rd(`SVM_ADDR_IRQ_STAT, 8'h02);
            wait_out(1'b0, 1'b0, 3);
        end
        wr(`SVM_ADDR_IRQ_MASK, 8'h00);
        rail[2] <= 1'b0;
        idle(10);
        rail[2] <= 1'b1;
        idle(10);
        wait_out(1'b0, 1'b0, 0);
        rd(`SVM_ADDR_IRQ_STAT, 8'h02);
        wr(`SVM_ADDR_IRQ_MASK, 8'h02);
        for (d = 0; d < 4; d++) begin
            wr(`SVM_ADDR_CTRL2, {4'h0, d[1:0], 2'h3});
            idle(160 << d);
            rd(`SVM_ADDR_IRQ_STAT, 8'h00);
            repeat (2) begin
                rail[2] <= !rail[2];
                wait_out(1'b0, 1'b1, (153 << d) + 40);
                check(8'(n >= (88 << d)), 8'h01);
                rd(`SVM_ADDR_IRQ_STAT, 8'h02);
            end
        end
        wr(`SVM_ADDR_CTRL2, 8'h11);
        rail[2] <= 1'b0;
        wait_out(1'b1, 1'b1, 20);
        wait_out(1'b1, 1'b0, 320);
        check(8'(n >= 248), 8'h01);
        rd(`SVM_ADDR_ENABLE, 8'h55);
        rd(`SVM_ADDR_STATUS, 8'h01);
        rail <= 3'h6;
        wait_out(1'b1, 1'b1, 20);
        idle(400);
        wait_out(1'b1, 1'b1, 0);
        rail[0] <= 1'b1;
        wait_out(1'b1, 1'b0, 320);
        check(8'(n >= 248), 8'h01);
        wr(`SVM_ADDR_ENABLE, 8'h07);
        rail[1] <= 1'b0;
        idle(20);
        rd(`SVM_ADDR_STATUS, 8'h02);
        rail[1] <= 1'b1;
        idle(5);
        rd(`SVM_ADDR_STATUS, 8'h03);
        idle(1800);
        tally_and_finish();
    end
endmodule : tb_supply_voltage_monitor_logic
`default_nettype wire
